// ==== bsd_decode.sv ====
`timescale 1ns/10ps
`default_nettype none
module bsd_decode
  import bsd_pkg::*;
#(
  parameter int unsigned XLEN = XLEN_DEF
)(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [INSN_W-1:0] instr,
  output logic instr_ready,
  input wire logic cond_flag,
  input wire logic priv_mode,
  input wire logic fetch_req,
  input wire logic data_req,
  input wire logic ld_pending,
  input wire logic [3:0] ld_dest,
  input wire logic ld_done,
  input wire logic wake_req,
  output logic op_valid,
  output bsd_op_t op_kind,
  output logic [3:0] reg_n,
  output logic [3:0] reg_m,
  output logic [2:0] ctrl_idx,
  output logic [XLEN-1:0] disp_out,
  output bsd_tgt_t target_sel,
  output logic branch_taken,
  output logic delay_slot,
  output logic save_ret,
  output logic restore_exc,
  output logic tlb_we,
  output logic cache_fill_hint_req,
  output logic ctrl_we,
  output logic gpr_we,
  output logic flag_we,
  output logic flag_wd,
  output logic priv_fault,
  output logic sleeping
);
  if (XLEN < 16)
  begin
    $error("XLEN too narrow for the scaled displacement");
  end

  typedef struct packed {
    bsd_mode_t mode;
    logic [2:0] cnt;
    logic op_valid;
    bsd_op_t op;
    logic [3:0] rn;
    logic [3:0] rm;
    logic [2:0] cidx;
    logic [XLEN-1:0] disp;
    bsd_tgt_t tgt;
    logic taken;
    logic delayed;
    logic save_ret;
    logic restore_exc;
    logic tlb_we;
    logic cache_fill_hint;
    logic ctrl_we;
    logic gpr_we;
    logic flag_we;
    logic flag_wd;
    logic fault;
  } bsd_state_t;

  bsd_state_t st_r;
  bsd_state_t st_nxt;
  bsd_op_t dop;
  logic acc;
  logic rd_src;
  logic [3:0] src;
  logic hazard;
  logic mem_clash;
  logic privileged;
  logic [XLEN-1:0] d8;
  logic [XLEN-1:0] d12;

  function automatic bsd_op_t dec_op(input logic [INSN_W-1:0] i);
    bsd_op_t o;
    o = OP_ILL;
    casez (i)
      PAT_BF, PAT_BFD: o = OP_BF;
      PAT_BT, PAT_BTD: o = OP_BT;
      PAT_JREL: o = OP_JREL;
      PAT_CREL: o = OP_CREL;
      PAT_SRET: o = OP_SRET;
      PAT_ERET: o = OP_ERET;
      PAT_SLEEP: o = OP_SLEEP;
      PAT_TLB: o = OP_TLB;
      PAT_CLRT: o = OP_CLRT;
      PAT_SETT: o = OP_SETT;
      PAT_NOP: o = OP_NOP;
      PAT_JRR: o = OP_JRR;
      PAT_CRR: o = OP_CRR;
      PAT_CACHE_FILL_HINT: o = OP_CACHE_FILL_HINT;
      PAT_JABS: o = OP_JABS;
      PAT_CABS: o = OP_CABS;
      PAT_CLD: o = i[7] ? OP_ILL : OP_CLD;
      PAT_CST: o = i[7] ? OP_ILL : OP_CST;
      PAT_SST: o = (i[7:6] != 2'h0) ? OP_ILL : OP_SST;
      default: o = OP_ILL;
    endcase
    return o;
  endfunction

  assign dop = dec_op(instr);
  // Register fields index R0..R15 straight from their binary value
  // Every register-reading form, control load included, names its source in bits 11:8
  assign src = instr[RN_LSB +: 4];
  assign rd_src = dop inside {OP_JRR, OP_CRR, OP_JABS, OP_CABS, OP_CACHE_FILL_HINT, OP_CLD};
  assign hazard = ld_pending && !ld_done && rd_src && (src == ld_dest);
  assign mem_clash = fetch_req && data_req;
  // Run mode, the counter and stalls gate issue, so states can grow but never shrink
  assign instr_ready = (st_r.mode == M_RUN) && (st_r.cnt == 3'h0) && !mem_clash && !hazard;
  assign acc = instr_valid && instr_ready;
  assign privileged = (dop inside {OP_ERET, OP_SLEEP, OP_TLB})
    || ((dop inside {OP_CLD, OP_CST}) && (instr[CIDX_LSB +: 3] != CIDX_USER));
  // Branch operands are word sized, so both displacement forms scale by two
  assign d8 = XLEN'($signed(instr[7:0])) << SC_WORD;
  assign d12 = XLEN'($signed(instr[11:0])) << SC_WORD;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.op_valid = 1'b0;
    st_nxt.taken = 1'b0;
    st_nxt.save_ret = 1'b0;
    st_nxt.restore_exc = 1'b0;
    st_nxt.tlb_we = 1'b0;
    st_nxt.cache_fill_hint = 1'b0;
    st_nxt.ctrl_we = 1'b0;
    st_nxt.gpr_we = 1'b0;
    st_nxt.flag_we = 1'b0;
    st_nxt.fault = 1'b0;
    if (st_r.mode == M_SLEEP)
    begin
      if (wake_req)
        st_nxt.mode = M_RUN;
    end
    else if (st_r.cnt != 3'h0)
      st_nxt.cnt = st_r.cnt - 3'h1;
    if (acc)
    begin
      st_nxt.op_valid = 1'b1;
      st_nxt.op = dop;
      st_nxt.rn = instr[RN_LSB +: 4];
      st_nxt.rm = instr[RM_LSB +: 4];
      st_nxt.cidx = instr[CIDX_LSB +: 3];
      st_nxt.disp = '0;
      st_nxt.tgt = TGT_NONE;
      st_nxt.delayed = 1'b0;
      st_nxt.cnt = ST_ONE - 3'h1;
      if (privileged && !priv_mode)
        st_nxt.fault = 1'b1;
      else
      begin
        case (dop)
          OP_BF, OP_BT:
          begin
            st_nxt.tgt = TGT_PC_DISP;
            st_nxt.disp = d8;
            st_nxt.delayed = instr[DELAY_BIT];
            st_nxt.taken = (dop == OP_BF) ? !cond_flag : cond_flag;
            if (st_nxt.taken)
              st_nxt.cnt = (instr[DELAY_BIT] ? ST_BR_DLY : ST_BR_TAKEN) - 3'h1;
          end
          OP_JREL, OP_CREL:
          begin
            st_nxt.tgt = TGT_PC_DISP;
            st_nxt.disp = d12;
            st_nxt.delayed = 1'b1;
            st_nxt.taken = 1'b1;
            st_nxt.save_ret = (dop == OP_CREL);
            st_nxt.cnt = ST_JUMP - 3'h1;
          end
          OP_JRR, OP_CRR, OP_JABS, OP_CABS:
          begin
            st_nxt.tgt = (dop inside {OP_JRR, OP_CRR}) ? TGT_PC_REG : TGT_REG;
            st_nxt.delayed = 1'b1;
            st_nxt.taken = 1'b1;
            st_nxt.save_ret = (dop inside {OP_CRR, OP_CABS});
            st_nxt.cnt = ST_JUMP - 3'h1;
          end
          OP_SRET:
          begin
            st_nxt.tgt = TGT_PR;
            st_nxt.delayed = 1'b1;
            st_nxt.taken = 1'b1;
            st_nxt.cnt = ST_JUMP - 3'h1;
          end
          OP_ERET:
          begin
            st_nxt.tgt = TGT_SPC;
            st_nxt.delayed = 1'b1;
            st_nxt.taken = 1'b1;
            st_nxt.restore_exc = 1'b1;
            st_nxt.cnt = ST_ERET - 3'h1;
          end
          OP_SLEEP: st_nxt.mode = M_SLEEP;
          OP_TLB: st_nxt.tlb_we = 1'b1;
          OP_CACHE_FILL_HINT: st_nxt.cache_fill_hint = 1'b1;
          OP_CLD:
          begin
            st_nxt.ctrl_we = 1'b1;
            st_nxt.cnt = ST_CLD - 3'h1;
          end
          OP_CST:
          begin
            st_nxt.gpr_we = 1'b1;
            st_nxt.cnt = ST_CST - 3'h1;
          end
          OP_SST: st_nxt.gpr_we = 1'b1;
          OP_CLRT, OP_SETT:
          begin
            st_nxt.flag_we = 1'b1;
            st_nxt.flag_wd = (dop == OP_SETT);
          end
          default: st_nxt.fault = (dop == OP_ILL);
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_r <= '0;
      st_r.mode <= M_RUN;
      st_r.op <= OP_NONE;
      st_r.tgt <= TGT_NONE;
    end
    else
      st_r <= st_nxt;
  end

  assign op_valid = st_r.op_valid;
  assign op_kind = st_r.op;
  assign reg_n = st_r.rn;
  assign reg_m = st_r.rm;
  assign ctrl_idx = st_r.cidx;
  assign disp_out = st_r.disp;
  assign target_sel = st_r.tgt;
  assign branch_taken = st_r.taken;
  assign delay_slot = st_r.delayed;
  assign save_ret = st_r.save_ret;
  assign restore_exc = st_r.restore_exc;
  assign tlb_we = st_r.tlb_we;
  assign cache_fill_hint_req = st_r.cache_fill_hint;
  assign ctrl_we = st_r.ctrl_we;
  assign gpr_we = st_r.gpr_we;
  // Flag write only for explicit set and clear, so the flag is held otherwise
  assign flag_we = st_r.flag_we;
  assign flag_wd = st_r.flag_wd;
  assign priv_fault = st_r.fault;
  assign sleeping = (st_r.mode == M_SLEEP);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_BF_TAKEN: assert property (acc && dop == OP_BF |=> op_valid && branch_taken == !$past(cond_flag))
    else $error("branch-if-false took wrong direction");
  AST_BT_TAKEN: assert property (acc && dop == OP_BT |=> op_valid && branch_taken == $past(cond_flag))
    else $error("branch-if-true took wrong direction");
  AST_REG_FIELDS: assert property (acc |=> reg_n == $past(instr[11:8]) && reg_m == $past(instr[7:4]))
    else $error("register field mismatch");
  AST_ERET_STATES: assert property (acc && dop == OP_ERET && priv_mode |=> !instr_ready [*3])
    else $error("exception return shorter than minimum");
  AST_MEM_CLASH: assert property (fetch_req && data_req |-> !instr_ready)
    else $error("issue during memory conflict");
  AST_LOAD_USE: assert property ((hazard |-> !instr_ready) and
    (hazard ##1 (ld_pending && !ld_done && $stable(instr) && $stable(ld_dest)) |-> !instr_ready))
    else $error("issue while load result pending");
  AST_DISP_SCALE: assert property (acc && dop == OP_JREL |=> disp_out == XLEN'($signed({$past(instr[11:0]), 1'b0})))
    else $error("relative displacement not scaled by two");
  AST_SLEEP: assert property (acc && dop == OP_SLEEP && priv_mode |=> sleeping && !instr_ready)
    else $error("sleep did not halt issue");
  AST_ERET: assert property (acc && dop == OP_ERET && priv_mode |=> restore_exc && branch_taken && target_sel == TGT_SPC)
    else $error("exception return did not restore");
  AST_SRET: assert property (acc && dop == OP_SRET |=> branch_taken && target_sel == TGT_PR && !save_ret)
    else $error("subroutine return target wrong");
  AST_CALL: assert property (acc && dop inside {OP_CREL, OP_CRR, OP_CABS} |=> save_ret && branch_taken)
    else $error("call did not save return address");
  AST_TLB: assert property (acc && dop == OP_TLB && priv_mode |=> tlb_we && !gpr_we)
    else $error("page entry load missing");
  AST_CACHE_FILL_HINT: assert property (acc && dop == OP_CACHE_FILL_HINT |=> cache_fill_hint_req && !gpr_we)
    else $error("prefetch misbehaved");
  AST_CTRL_PRIV: assert property (acc && dop == OP_CLD && !priv_mode && instr[6:4] != CIDX_USER |=> priv_fault && !ctrl_we)
    else $error("user mode control write not refused");
  AST_SYS_STORE: assert property (acc && dop == OP_SST |=> gpr_we && ctrl_idx == $past(instr[6:4]))
    else $error("system register store wrong");
  AST_FLAG_HOLD: assert property (acc && !(dop inside {OP_CLRT, OP_SETT}) |=> !flag_we)
    else $error("flag written by non-flag instruction");

  COV_BF_TAKEN: cover property (acc && dop == OP_BF && !cond_flag ##1 branch_taken);
  COV_SLEEP_WAKE: cover property (sleeping ##1 wake_req ##1 instr_ready);
  COV_LOAD_STALL: cover property (hazard ##1 !hazard && instr_ready);
endmodule
`default_nettype wire

// ==== bsd_pkg.sv ====
`default_nettype none
package bsd_pkg;
  localparam int unsigned INSN_W = 16;
  localparam int unsigned XLEN_DEF = 32;
  localparam int unsigned RN_LSB = 8;
  localparam int unsigned RM_LSB = 4;
  localparam int unsigned CIDX_LSB = 4;
  localparam int unsigned SIDX_LSB = 4;
  localparam int unsigned DELAY_BIT = 10;
  // Displacement scale shifts for byte, word and long operands
  localparam logic [1:0] SC_BYTE = 2'h0;
  localparam logic [1:0] SC_WORD = 2'h1;
  localparam logic [1:0] SC_LONG = 2'h2;
  // Control register index usable from user mode
  localparam logic [2:0] CIDX_USER = 3'h1;
  // Minimum execution states
  localparam logic [2:0] ST_ONE = 3'h1;
  localparam logic [2:0] ST_BR_TAKEN = 3'h3;
  localparam logic [2:0] ST_BR_DLY = 3'h2;
  localparam logic [2:0] ST_JUMP = 3'h2;
  localparam logic [2:0] ST_ERET = 3'h4;
  localparam logic [2:0] ST_CLD = 3'h4;
  localparam logic [2:0] ST_CST = 3'h2;
  // Instruction patterns
  localparam logic [15:0] PAT_BF = 16'h8b??;
  localparam logic [15:0] PAT_BFD = 16'h8f??;
  localparam logic [15:0] PAT_BT = 16'h89??;
  localparam logic [15:0] PAT_BTD = 16'h8d??;
  localparam logic [15:0] PAT_JREL = 16'ha???;
  localparam logic [15:0] PAT_CREL = 16'hb???;
  localparam logic [15:0] PAT_JRR = 16'h0?23;
  localparam logic [15:0] PAT_CRR = 16'h0?03;
  localparam logic [15:0] PAT_JABS = 16'h4?2b;
  localparam logic [15:0] PAT_CABS = 16'h4?0b;
  localparam logic [15:0] PAT_SRET = 16'h000b;
  localparam logic [15:0] PAT_ERET = 16'h002b;
  localparam logic [15:0] PAT_SLEEP = 16'h001b;
  localparam logic [15:0] PAT_TLB = 16'h0038;
  localparam logic [15:0] PAT_CACHE_FILL_HINT = 16'h0?83;
  localparam logic [15:0] PAT_CLRT = 16'h0008;
  localparam logic [15:0] PAT_SETT = 16'h0018;
  localparam logic [15:0] PAT_NOP = 16'h0009;
  localparam logic [15:0] PAT_CLD = 16'h4??e;
  localparam logic [15:0] PAT_CST = 16'h0??2;
  localparam logic [15:0] PAT_SST = 16'h0??a;
  typedef enum logic [4:0] {
    OP_NONE, OP_BF, OP_BT, OP_JREL, OP_JRR, OP_CREL, OP_CRR, OP_JABS,
    OP_CABS, OP_SRET, OP_ERET, OP_SLEEP, OP_TLB, OP_CACHE_FILL_HINT, OP_CLD, OP_CST,
    OP_SST, OP_CLRT, OP_SETT, OP_NOP, OP_ILL
  } bsd_op_t;
  typedef enum logic [2:0] {
    TGT_NONE, TGT_PC_DISP, TGT_PC_REG, TGT_REG, TGT_PR, TGT_SPC
  } bsd_tgt_t;
  typedef enum logic {M_RUN, M_SLEEP} bsd_mode_t;
endpackage
`default_nettype wire

// ==== tb_cpu_branch_sysctl_decode.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_cpu_branch_sysctl_decode;
  import bsd_pkg::*;
  logic sys_clk, rst, instr_valid, cond_flag, priv_mode, fetch_req, data_req, ld_pending, ld_done, wake_req;
  logic [15:0] instr;
  logic [3:0] ld_dest;
  logic instr_ready, op_valid, branch_taken, delay_slot, save_ret, restore_exc, tlb_we, cache_fill_hint_req;
  logic ctrl_we, gpr_we, flag_we, flag_wd, priv_fault, sleeping;
  bsd_op_t op_kind;
  bsd_tgt_t target_sel;
  logic [3:0] reg_n, reg_m;
  logic [2:0] ctrl_idx;
  logic [31:0] disp_out;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;

  bsd_decode #(.XLEN(32)) dut (.sys_clk(sys_clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .instr_ready(instr_ready), .cond_flag(cond_flag), .priv_mode(priv_mode), .fetch_req(fetch_req),
    .data_req(data_req), .ld_pending(ld_pending), .ld_dest(ld_dest), .ld_done(ld_done),
    .wake_req(wake_req), .op_valid(op_valid), .op_kind(op_kind), .reg_n(reg_n), .reg_m(reg_m),
    .ctrl_idx(ctrl_idx), .disp_out(disp_out), .target_sel(target_sel), .branch_taken(branch_taken),
    .delay_slot(delay_slot), .save_ret(save_ret), .restore_exc(restore_exc), .tlb_we(tlb_we),
    .cache_fill_hint_req(cache_fill_hint_req), .ctrl_we(ctrl_we), .gpr_we(gpr_we), .flag_we(flag_we), .flag_wd(flag_wd),
    .priv_fault(priv_fault), .sleeping(sleeping));

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Ceiling well above the under one hundred cycles the tests need
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_count++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Offers one word, judges the issue cycle, then counts states until ready returns
  // Pulses: valid, taken, save, restore, tlb, cache_fill_hint, ctrl_we, gpr_we, flag_we, fault
  task automatic run(input logic [15:0] w, input logic f, input logic p, input bsd_op_t k,
                     input bsd_tgt_t t, input logic ct, input logic [9:0] pu, input int st);
    int n;
    cond_flag = f;
    priv_mode = p;
    instr = w;
    instr_valid = 1'b1;
    n = 0;
    // Let the combinational ready settle on the new word before it is read
    #1;
    while (instr_ready !== 1'b1 && n < 50)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    @(posedge sys_clk);
    #1;
    instr_valid = 1'b0;
    chk("op_kind", k, op_kind);
    if (ct)
      chk("target_sel", t, target_sel);
    chk("pulses", pu, {op_valid, branch_taken, save_ret, restore_exc, tlb_we, cache_fill_hint_req, ctrl_we, gpr_we,
        flag_we, priv_fault});
    if (st > 0)
    begin
      n = 1;
      while (instr_ready !== 1'b1 && n < 50)
      begin
        @(posedge sys_clk);
        #1;
        n++;
      end
      chk("states", st, n);
    end
  endtask

  task automatic t_cond();
    run(16'h8b10, 1'b0, 1'b1, OP_BF, TGT_PC_DISP, 1'b1, 10'h300, 3);
    chk("disp_out", 32'h00000020, disp_out);
    run(16'h8b10, 1'b1, 1'b1, OP_BF, TGT_NONE, 1'b0, 10'h200, 1);
    run(16'h8f10, 1'b0, 1'b1, OP_BF, TGT_PC_DISP, 1'b1, 10'h300, 2);
    chk("delay_slot", 1, delay_slot);
    run(16'h8980, 1'b1, 1'b1, OP_BT, TGT_PC_DISP, 1'b1, 10'h300, 3);
    chk("disp_out", 32'hffffff00, disp_out);
    run(16'h8910, 1'b0, 1'b1, OP_BT, TGT_NONE, 1'b0, 10'h200, 1);
    run(16'h8d10, 1'b1, 1'b0, OP_BT, TGT_PC_DISP, 1'b1, 10'h300, 2);
    $display("test cond done");
  endtask

  task automatic t_jump();
    run(16'hafff, 1'b0, 1'b1, OP_JREL, TGT_PC_DISP, 1'b1, 10'h300, 2);
    chk("disp_out", 32'hfffffffe, disp_out);
    run(16'hb001, 1'b0, 1'b1, OP_CREL, TGT_PC_DISP, 1'b1, 10'h380, 2);
    chk("disp_out", 32'h00000002, disp_out);
    run(16'h0f23, 1'b0, 1'b1, OP_JRR, TGT_PC_REG, 1'b1, 10'h300, 2);
    chk("reg_n", 15, reg_n);
    run(16'h0003, 1'b1, 1'b1, OP_CRR, TGT_PC_REG, 1'b1, 10'h380, 2);
    chk("reg_n", 0, reg_n);
    run(16'h4a2b, 1'b0, 1'b0, OP_JABS, TGT_REG, 1'b1, 10'h300, 2);
    run(16'h4b0b, 1'b0, 1'b0, OP_CABS, TGT_REG, 1'b1, 10'h380, 2);
    run(16'h000b, 1'b0, 1'b0, OP_SRET, TGT_PR, 1'b1, 10'h300, 2);
    run(16'h002b, 1'b0, 1'b1, OP_ERET, TGT_SPC, 1'b1, 10'h340, 4);
    run(16'h002b, 1'b0, 1'b0, OP_ERET, TGT_NONE, 1'b0, 10'h201, 1);
    $display("test jump done");
  endtask

  task automatic t_sys();
    run(16'h0038, 1'b0, 1'b1, OP_TLB, TGT_NONE, 1'b0, 10'h220, 1);
    run(16'h0038, 1'b0, 1'b0, OP_TLB, TGT_NONE, 1'b0, 10'h201, 1);
    run(16'h0783, 1'b1, 1'b0, OP_CACHE_FILL_HINT, TGT_NONE, 1'b0, 10'h210, 1);
    run(16'h431e, 1'b0, 1'b0, OP_CLD, TGT_NONE, 1'b0, 10'h208, 4);
    chk("reg_n", 3, reg_n);
    chk("reg_m", 1, reg_m);
    run(16'h432e, 1'b0, 1'b0, OP_CLD, TGT_NONE, 1'b0, 10'h201, 1);
    run(16'h432e, 1'b0, 1'b1, OP_CLD, TGT_NONE, 1'b0, 10'h208, 4);
    chk("ctrl_idx", 2, ctrl_idx);
    run(16'h0512, 1'b0, 1'b0, OP_CST, TGT_NONE, 1'b0, 10'h204, 2);
    run(16'h0522, 1'b0, 1'b0, OP_CST, TGT_NONE, 1'b0, 10'h201, 1);
    run(16'h052a, 1'b0, 1'b0, OP_SST, TGT_NONE, 1'b0, 10'h204, 1);
    chk("reg_n", 5, reg_n);
    run(16'h0018, 1'b0, 1'b0, OP_SETT, TGT_NONE, 1'b0, 10'h202, 1);
    chk("flag_wd", 1, flag_wd);
    run(16'h0008, 1'b1, 1'b0, OP_CLRT, TGT_NONE, 1'b0, 10'h202, 1);
    chk("flag_wd", 0, flag_wd);
    run(16'h0009, 1'b1, 1'b0, OP_NOP, TGT_NONE, 1'b0, 10'h200, 1);
    run(16'hffff, 1'b1, 1'b0, OP_ILL, TGT_NONE, 1'b0, 10'h201, 1);
    $display("test sys done");
  endtask

  task automatic t_sleep();
    run(16'h001b, 1'b0, 1'b1, OP_SLEEP, TGT_NONE, 1'b0, 10'h200, 0);
    repeat (3)
    begin
      chk("sleeping", 1, sleeping);
      chk("ready", 0, instr_ready);
      @(posedge sys_clk);
      #1;
    end
    wake_req = 1'b1;
    @(posedge sys_clk);
    #1;
    wake_req = 1'b0;
    chk("sleeping", 0, sleeping);
    chk("ready", 1, instr_ready);
    $display("test sleep done");
  endtask

  task automatic t_stall();
    fetch_req = 1'b1;
    data_req = 1'b1;
    instr = 16'h0009;
    instr_valid = 1'b1;
    repeat (2)
    begin
      @(posedge sys_clk);
      #1;
      chk("ready", 0, instr_ready);
      chk("op_valid", 0, op_valid);
    end
    instr_valid = 1'b0;
    data_req = 1'b0;
    run(16'h0009, 1'b0, 1'b0, OP_NOP, TGT_NONE, 1'b0, 10'h200, 1);
    // Load into R5 still in flight; only a reader of R5 is held back
    ld_pending = 1'b1;
    ld_dest = 4'h5;
    instr = 16'h462b;
    @(posedge sys_clk);
    #1;
    chk("ready", 1, instr_ready);
    instr = 16'h452b;
    @(posedge sys_clk);
    #1;
    chk("ready", 0, instr_ready);
    ld_done = 1'b1;
    run(16'h452b, 1'b0, 1'b0, OP_JABS, TGT_REG, 1'b1, 10'h300, 2);
    ld_pending = 1'b0;
    ld_done = 1'b0;
    fetch_req = 1'b0;
    $display("test stall done");
  endtask

  initial
  begin
    rst = 1'b1;
    instr_valid = 1'b0;
    instr = 16'h0000;
    cond_flag = 1'b0;
    priv_mode = 1'b0;
    fetch_req = 1'b0;
    data_req = 1'b0;
    ld_pending = 1'b0;
    ld_dest = 4'h0;
    ld_done = 1'b0;
    wake_req = 1'b0;
    repeat (12) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    @(posedge sys_clk);
    #1;
    chk("op_kind", OP_NONE, op_kind);
    chk("sleeping", 0, sleeping);
    chk("ready", 1, instr_ready);
    $display("test reset done");
    t_cond();
    t_jump();
    t_sys();
    t_sleep();
    t_stall();
    complete_run();
  end
endmodule
`default_nettype wire
